/* File: rtl/hpm_pin_mux.sv */
// Host port pin-function multiplexer: data, address-low, strobe and select pins
`timescale 1ns/1ps

// What this block does
// - Pin functions follow the 16-bit control: non-multiplexed, multiplexed or GPIO
// - Non-multiplexed host mode: eight data pins are bidirectional data lines 0-7
// - Multiplexed host mode: same eight pins carry shared address/data lines 0-7
// - GPIO mode: each pin input or output per its direction bit
// - Pin 0: address bit 0, address strobe, or GPIO bit 8
// - Address strobe polarity is selectable, active low after reset
// - Pin 1: address bit 1, high address bit 8, or GPIO bit 9
// - Pin 2: address bit 2, high address bit 9, or GPIO bit 10
// - Pin 3: chip select, high address bit 10, or GPIO bit 13
// - Chip select polarity is selectable, active low after reset
// - Stop: former outputs go high impedance, inputs are ignored
// - Wait state changes no pin function, direction or drive
module hpm_pin_mux (
  input  wire logic        ref_clk,         // Core clock, 20 MHz
  input  wire logic        rst_b,           // Synchronous reset, active low
  input  wire logic        ctrlWr,          // Load port control register
  input  wire logic [15:0] ctrlIn,          // New port control value
  output logic      [15:0] ctrlRd,          // Port control readback
  input  wire logic [15:0] gpioDir,         // Direction per port bit, 1 = output
  input  wire logic [15:0] gpioOut,         // Output value per port bit
  output logic      [15:0] gpioIn,          // Sampled port bits in GPIO mode
  input  wire logic        stopMode,        // Core in stop state
  input  wire logic        waitMode,        // Core in wait state
  input  wire logic [7:0]  hostDataOut,     // Read data from host logic
  input  wire logic        hostDrive,       // Host logic drives data pins
  output logic      [7:0]  hostDataIn,      // Data or address/data from pins
  output logic      [2:0]  hostAddrIn,      // Address bits 0-2, non-multiplexed
  output logic      [2:0]  highAddrIn,      // Address bits 8-10, multiplexed
  output logic             addressStrobeIn, // Address strobe, 1 = asserted
  output logic             hostSelectIn,    // Chip select, 1 = asserted
  input  wire logic [7:0]  dataPinIn,       // Data pin levels
  output logic      [7:0]  dataPinOut,      // Data pin drive values
  output logic      [7:0]  dataPinOe,       // Data pin enables, 1 = driving
  input  wire logic [3:0]  addrPinIn,       // Address-side pin levels
  output logic      [3:0]  addrPinOut,      // Address-side pin drive values
  output logic      [3:0]  addrPinOe        // Address-side pin enables, 1 = driving
);

  ////////////////////////////////////////////////////////////////////////////////

  hpm_pkg::hpm_state_t st_ff;
  hpm_pkg::hpm_state_t nxt_st;
  hpm_pkg::hpm_mode_t  curMode;

  assign curMode = hpm_pkg::modeOf(st_ff.ctrl);

  always_comb begin
    nxt_st = st_ff;
    if (stopMode) begin
      // Every pin floats; sensed values freeze so stale inputs are ignored
      nxt_st.drive.dataOe = 8'h00;
      nxt_st.drive.addrOe = 4'h0;
    end else begin
      // Wait mode is deliberately not looked at here
      if (ctrlWr) begin
        nxt_st.ctrl = ctrlIn;
      end
      // Fields owned by another mode keep their last value, except strobe and select, which are cleared to 0
      // Control write lands first; pins switch one edge later
      case (curMode)
        hpm_pkg::MODE_NONMUX: begin
          nxt_st.drive.dataOut = hostDataOut;
          nxt_st.drive.dataOe  = {8{hostDrive}};
          nxt_st.drive.addrOe  = 4'h0;
          nxt_st.sense.hostData = dataPinIn;
          nxt_st.sense.lowAddr  = addrPinIn[2:0];
          nxt_st.sense.strobe   = 1'b0;
          nxt_st.sense.select   = hpm_pkg::assertedOf(addrPinIn[3],
                                    st_ff.ctrl[hpm_pkg::CTRL_SELECT_POL]);
        end
        hpm_pkg::MODE_MUX: begin
          nxt_st.drive.dataOut = hostDataOut;
          nxt_st.drive.dataOe  = {8{hostDrive}};
          nxt_st.drive.addrOe  = 4'h0;
          nxt_st.sense.hostData = dataPinIn;
          nxt_st.sense.highAddr = addrPinIn[3:1];
          nxt_st.sense.strobe   = hpm_pkg::assertedOf(addrPinIn[0],
                                    st_ff.ctrl[hpm_pkg::CTRL_STROBE_POL]);
          nxt_st.sense.select   = 1'b0;
        end
        default: begin
          nxt_st.drive.dataOut = gpioOut[7:0];
          nxt_st.drive.dataOe  = gpioDir[7:0];
          nxt_st.drive.addrOut = {gpioOut[hpm_pkg::GPIO_BIT_PIN3],
                                  gpioOut[hpm_pkg::GPIO_BIT_PIN2],
                                  gpioOut[hpm_pkg::GPIO_BIT_PIN1],
                                  gpioOut[hpm_pkg::GPIO_BIT_PIN0]};
          nxt_st.drive.addrOe  = {gpioDir[hpm_pkg::GPIO_BIT_PIN3],
                                  gpioDir[hpm_pkg::GPIO_BIT_PIN2],
                                  gpioDir[hpm_pkg::GPIO_BIT_PIN1],
                                  gpioDir[hpm_pkg::GPIO_BIT_PIN0]};
          nxt_st.sense.strobe  = 1'b0;
          nxt_st.sense.select  = 1'b0;
          nxt_st.sense.gpioIn[7:0] = dataPinIn;
          nxt_st.sense.gpioIn[hpm_pkg::GPIO_BIT_PIN0] = addrPinIn[0];
          nxt_st.sense.gpioIn[hpm_pkg::GPIO_BIT_PIN1] = addrPinIn[1];
          nxt_st.sense.gpioIn[hpm_pkg::GPIO_BIT_PIN2] = addrPinIn[2];
          nxt_st.sense.gpioIn[hpm_pkg::GPIO_BIT_PIN3] = addrPinIn[3];
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      // Reset value floats all pins and selects active-low strobes
      st_ff <= hpm_pkg::STATE_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  assign ctrlRd          = st_ff.ctrl;
  assign gpioIn          = st_ff.sense.gpioIn;
  assign hostDataIn      = st_ff.sense.hostData;
  assign hostAddrIn      = st_ff.sense.lowAddr;
  assign highAddrIn      = st_ff.sense.highAddr;
  assign addressStrobeIn = st_ff.sense.strobe;
  assign hostSelectIn    = st_ff.sense.select;
  assign dataPinOut      = st_ff.drive.dataOut;
  assign dataPinOe       = st_ff.drive.dataOe;
  assign addrPinOut      = st_ff.drive.addrOut;
  assign addrPinOe       = st_ff.drive.addrOe;

  ////////////////////////////////////////////////////////////////////////////////

  chk_ctrl_load: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (ctrlWr && !stopMode) |=> (ctrlRd == $past(ctrlIn)))
    else $error("Port control value not loaded");

  chk_nonmux_data: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (curMode == hpm_pkg::MODE_NONMUX && !stopMode)
      |=> (dataPinOe == {8{$past(hostDrive)}}) && (dataPinOut == $past(hostDataOut))
          && (hostDataIn == $past(dataPinIn)) && (addrPinOe == 4'h0))
    else $error("Non-multiplexed data pins wrong");

  chk_mux_data: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (curMode == hpm_pkg::MODE_MUX && !stopMode)
      |=> (dataPinOe == {8{$past(hostDrive)}}) && (hostDataIn == $past(dataPinIn))
          && !hostSelectIn)
    else $error("Multiplexed address/data pins wrong");

  chk_gpio_dir: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (curMode == hpm_pkg::MODE_GPIO && !stopMode)
      |=> (dataPinOe == $past(gpioDir[7:0])) && (dataPinOut == $past(gpioOut[7:0]))
          && (gpioIn[7:0] == $past(dataPinIn)))
    else $error("GPIO data pin direction wrong");

  chk_pin0_func: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (curMode == hpm_pkg::MODE_NONMUX && !stopMode)
      |=> (hostAddrIn[0] == $past(addrPinIn[0])) && !addressStrobeIn)
    else $error("Pin 0 address function wrong");

  chk_strobe_pol: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (curMode == hpm_pkg::MODE_MUX && !stopMode)
      |=> (addressStrobeIn
           == ($past(ctrlRd[hpm_pkg::CTRL_STROBE_POL]) ? $past(addrPinIn[0])
                                                       : !$past(addrPinIn[0]))))
    else $error("Address strobe polarity wrong");

  chk_pin1_func: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (curMode == hpm_pkg::MODE_MUX && !stopMode) |=> (highAddrIn[0] == $past(addrPinIn[1])))
    else $error("Pin 1 high address function wrong");

  chk_pin2_func: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (curMode == hpm_pkg::MODE_GPIO && !stopMode)
      |=> (addrPinOe[2] == $past(gpioDir[hpm_pkg::GPIO_BIT_PIN2]))
          && (gpioIn[hpm_pkg::GPIO_BIT_PIN2] == $past(addrPinIn[2])))
    else $error("Pin 2 GPIO function wrong");

  chk_pin3_func: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (curMode == hpm_pkg::MODE_GPIO && !stopMode)
      |=> (addrPinOe[3] == $past(gpioDir[hpm_pkg::GPIO_BIT_PIN3]))
          && (addrPinOut[3] == $past(gpioOut[hpm_pkg::GPIO_BIT_PIN3])))
    else $error("Pin 3 GPIO function wrong");

  chk_select_pol: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (curMode == hpm_pkg::MODE_NONMUX && !stopMode && !ctrlRd[hpm_pkg::CTRL_SELECT_POL])
      |=> (hostSelectIn == !$past(addrPinIn[3])))
    else $error("Chip select polarity wrong");

  chk_stop_float: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    stopMode |=> (dataPinOe == 8'h00) && (addrPinOe == 4'h0) && $stable(hostDataIn)
                 && $stable(gpioIn) && $stable(ctrlRd))
    else $error("Pins not floated or inputs not ignored in stop");

  chk_wait_same: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (waitMode && !stopMode && curMode == hpm_pkg::MODE_GPIO)
      |=> (addrPinOe == {$past(gpioDir[13]), $past(gpioDir[10:8])}))
    else $error("Wait state changed pin drive");

  chk_reset_quiet: assert property (
    @(posedge ref_clk)
    !rst_b |=> (dataPinOe == 8'h00) && (addrPinOe == 4'h0) && (ctrlRd == 16'h0000))
    else $error("Pin driven after reset");

  // Pins a mode does not own must read idle or hold their last value
  chk_strobe_idle: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (curMode != hpm_pkg::MODE_MUX && !stopMode) |=> !addressStrobeIn)
    else $error("Address strobe asserted outside multiplexed mode");

  chk_select_idle: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (curMode != hpm_pkg::MODE_NONMUX && !stopMode) |=> !hostSelectIn)
    else $error("Chip select asserted outside non-multiplexed mode");

  chk_select_high: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (curMode == hpm_pkg::MODE_NONMUX && !stopMode && ctrlRd[hpm_pkg::CTRL_SELECT_POL])
      |=> (hostSelectIn == $past(addrPinIn[3])))
    else $error("Active-high chip select wrong");

  chk_pin1_nonmux: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (curMode == hpm_pkg::MODE_NONMUX && !stopMode)
      |=> (hostAddrIn[1] == $past(addrPinIn[1])))
    else $error("Pin 1 low address function wrong");

  chk_pin2_nonmux: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (curMode == hpm_pkg::MODE_NONMUX && !stopMode)
      |=> (hostAddrIn[2] == $past(addrPinIn[2])))
    else $error("Pin 2 low address function wrong");

  chk_pin2_mux: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (curMode == hpm_pkg::MODE_MUX && !stopMode)
      |=> (highAddrIn[1] == $past(addrPinIn[2])))
    else $error("Pin 2 high address function wrong");

  chk_pin3_mux: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (curMode == hpm_pkg::MODE_MUX && !stopMode)
      |=> (highAddrIn[2] == $past(addrPinIn[3])))
    else $error("Pin 3 high address function wrong");

  chk_pin0_gpio: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (curMode == hpm_pkg::MODE_GPIO && !stopMode)
      |=> (addrPinOe[0] == $past(gpioDir[hpm_pkg::GPIO_BIT_PIN0]))
          && (addrPinOut[0] == $past(gpioOut[hpm_pkg::GPIO_BIT_PIN0]))
          && (gpioIn[hpm_pkg::GPIO_BIT_PIN0] == $past(addrPinIn[0])))
    else $error("Pin 0 GPIO function wrong");

  chk_pin1_gpio: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (curMode == hpm_pkg::MODE_GPIO && !stopMode)
      |=> (addrPinOe[1] == $past(gpioDir[hpm_pkg::GPIO_BIT_PIN1]))
          && (addrPinOut[1] == $past(gpioOut[hpm_pkg::GPIO_BIT_PIN1]))
          && (gpioIn[hpm_pkg::GPIO_BIT_PIN1] == $past(addrPinIn[1])))
    else $error("Pin 1 GPIO function wrong");

  chk_host_addr_in: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (curMode != hpm_pkg::MODE_GPIO && !stopMode) |=> (addrPinOe == 4'h0))
    else $error("Address-side pin driven in host mode");

  chk_mux_drive: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (curMode == hpm_pkg::MODE_MUX && !stopMode)
      |=> (dataPinOut == $past(hostDataOut)))
    else $error("Multiplexed data drive value wrong");

  chk_low_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (curMode != hpm_pkg::MODE_NONMUX && !stopMode) |=> $stable(hostAddrIn))
    else $error("Low address changed outside non-multiplexed mode");

  chk_high_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (curMode != hpm_pkg::MODE_MUX && !stopMode) |=> $stable(highAddrIn))
    else $error("High address changed outside multiplexed mode");

  chk_stop_sense: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    stopMode |=> $stable(hostAddrIn) && $stable(highAddrIn)
                 && $stable(addressStrobeIn) && $stable(hostSelectIn))
    else $error("Address or strobe inputs not ignored in stop");

  chk_ctrl_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (!ctrlWr || stopMode) |=> $stable(ctrlRd))
    else $error("Port control changed without a load");

endmodule

/* File: inc/hpm_pkg.sv */
// Constants, types and decode helpers for the host port pin-function multiplexer
package hpm_pkg;

  // Port control register layout (16 bits); unused bits are stored and read back
  localparam int          CTRL_W          = 16;
  localparam int          CTRL_HOST_EN    = 0;   // 1: host function, 0: general-purpose I/O
  localparam int          CTRL_MUXED      = 1;   // 1: multiplexed address/data bus
  localparam int          CTRL_STROBE_POL = 2;   // 1: address strobe active high
  localparam int          CTRL_SELECT_POL = 3;   // 1: chip select active high
  localparam logic [15:0] CTRL_RESET      = 16'h0000;

  // General-purpose port bit carried by each address-side pin
  localparam int          GPIO_W          = 16;
  localparam int          GPIO_BIT_PIN0   = 8;
  localparam int          GPIO_BIT_PIN1   = 9;
  localparam int          GPIO_BIT_PIN2   = 10;
  localparam int          GPIO_BIT_PIN3   = 13;

  localparam int          DATA_W          = 8;
  localparam int          APIN_W          = 4;

  typedef enum logic [1:0] {
    MODE_NONMUX = 2'b00,
    MODE_MUX    = 2'b01,
    MODE_GPIO   = 2'b10
  } hpm_mode_t;

  // Drive side of both pin groups
  typedef struct packed {
    logic [7:0] dataOut;
    logic [7:0] dataOe;
    logic [3:0] addrOut;
    logic [3:0] addrOe;
  } hpm_drive_t;

  // Values presented to the core from the pins
  typedef struct packed {
    logic [7:0]  hostData;
    logic [2:0]  lowAddr;
    logic [2:0]  highAddr;
    logic        strobe;
    logic        select;
    logic [15:0] gpioIn;
  } hpm_sense_t;

  typedef struct packed {
    logic [15:0] ctrl;
    hpm_drive_t  drive;
    hpm_sense_t  sense;
  } hpm_state_t;

  localparam hpm_state_t STATE_RESET = '{ctrl: CTRL_RESET, drive: '0, sense: '0};

  function automatic hpm_mode_t modeOf(input logic [15:0] ctrl);
    if (!ctrl[CTRL_HOST_EN]) begin
      return MODE_GPIO;
    end else if (ctrl[CTRL_MUXED]) begin
      return MODE_MUX;
    end
    return MODE_NONMUX;
  endfunction

  // Asserted level of a strobe pin; pol 0 means active low
  function automatic logic assertedOf(input logic pin, input logic pol);
    return ~(pin ^ pol);
  endfunction

endpackage

/* File: tb/hpm_host_model.sv */
// Host-side bus model: drives the port pins from outside and resolves each wire
`timescale 1ns/1ps
module hpm_host_model (
  input  wire logic       ref_clk,    // Core clock
  input  wire logic       hostEn,     // Host drives the data pins
  input  wire logic [7:0] hostData,   // Host data pin values
  input  wire logic [3:0] hostAddr,   // Host address-side pin values
  input  wire logic [7:0] dataPinOut, // Device data drive values
  input  wire logic [7:0] dataPinOe,  // Device data enables
  input  wire logic [3:0] addrPinOut, // Device address-side drive values
  input  wire logic [3:0] addrPinOe,  // Device address-side enables
  output logic      [7:0] dataPinIn,  // Resolved data wires
  output logic      [3:0] addrPinIn   // Resolved address-side wires
);
  logic [7:0] lastData = 8'h00;

  always @(posedge ref_clk) begin
    lastData <= dataPinIn;
  end

  // Undriven data lines toggle so a stale level never passes for valid data
  always_comb begin
    dataPinIn = (dataPinOe & dataPinOut) | (~dataPinOe & (hostEn ? hostData : ~lastData));
    addrPinIn = (addrPinOe & addrPinOut) | (~addrPinOe & hostAddr);
  end
endmodule

/* File: tb/hpm_pin_mux_tb.sv */
// Self-checking testbench for the host port pin-function multiplexer
`timescale 1ns/1ps
module hpm_pin_mux_tb;
  logic        ref_clk = 1'b0, rst_b = 1'b0, ctrlWr = 1'b0, stopMode = 1'b0, waitMode = 1'b0;
  logic        hostDrive = 1'b1, hostEn = 1'b0, addressStrobeIn, hostSelectIn;
  logic [15:0] ctrlIn = 16'h0000, gpioDir = 16'hFFFF, gpioOut = 16'hFFFF, ctrlRd, gpioIn;
  logic [7:0]  hostDataOut = 8'h00, hostData = 8'h00, hostDataIn, dataPinIn, dataPinOut, dataPinOe;
  logic [2:0]  hostAddrIn, highAddrIn;
  logic [3:0]  hostAddr = 4'h0, addrPinIn, addrPinOut, addrPinOe;
  int          errTotal = 0;
  int          nTests = 0;

  always #25 ref_clk = ~ref_clk;

  hpm_pin_mux hpm_pin_mux_i (.ref_clk, .rst_b, .ctrlWr, .ctrlIn, .ctrlRd, .gpioDir, .gpioOut,
    .gpioIn, .stopMode, .waitMode, .hostDataOut, .hostDrive, .hostDataIn, .hostAddrIn,
    .highAddrIn, .addressStrobeIn, .hostSelectIn, .dataPinIn, .dataPinOut, .dataPinOe,
    .addrPinIn, .addrPinOut, .addrPinOe);

  hpm_host_model hpm_host_model_i (.ref_clk, .hostEn, .hostData, .hostAddr, .dataPinOut,
    .dataPinOe, .addrPinOut, .addrPinOe, .dataPinIn, .addrPinIn);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nTests++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      errTotal++;
    end
  endtask

  task automatic endOfTest;
    $display("Comparisons %0d, mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Settle past the edge so registered outputs are read after they land
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask

  // Pins follow the new mode one edge after the load
  task automatic setCtrl(input logic [15:0] v);
    @(posedge ref_clk);
    ctrlWr <= 1'b1;
    ctrlIn <= v;
    @(posedge ref_clk);
    ctrlWr <= 1'b0;
    tick;
  endtask

  task automatic checkQuiet;
    chk({dataPinOe, addrPinOe}, 16'h0000);
    chk(ctrlRd, 16'h0000);
    chk({addressStrobeIn, hostSelectIn}, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Host data reaches the pins at the same edge the device lets go of them
  task automatic testNonMux;
    setCtrl(16'hA5F1);
    chk(ctrlRd, 16'hA5F1);
    @(posedge ref_clk);
    hostDrive <= 1'b0;
    hostEn <= 1'b1;
    hostData <= 8'h5A;
    hostAddr <= 4'b0110;
    repeat (2) tick;
    chk(hostDataIn, 16'h005A);
    chk(hostAddrIn, 16'h0006);
    chk({addressStrobeIn, hostSelectIn}, 16'h0001);
    chk({dataPinOe, addrPinOe}, 16'h0000);
    @(posedge ref_clk);
    hostEn <= 1'b0;
    hostDrive <= 1'b1;
    hostDataOut <= 8'hA5;
    tick;
    chk({dataPinOe, dataPinOut}, 16'hFFA5);
    setCtrl(16'h0009);
    chk(hostSelectIn, 16'h0000);
    @(posedge ref_clk);
    hostAddr <= 4'hE;
    tick;
    chk(hostSelectIn, 16'h0001);
  endtask

  task automatic testMux;
    setCtrl(16'h0003);
    @(posedge ref_clk);
    hostDrive <= 1'b0;
    hostEn <= 1'b1;
    hostData <= 8'hC3;
    hostAddr <= 4'b1010;
    repeat (2) tick;
    chk(hostDataIn, 16'h00C3);
    chk(highAddrIn, 16'h0005);
    chk(hostAddrIn, 16'h0006);
    chk({addressStrobeIn, hostSelectIn}, 16'h0002);
    setCtrl(16'h0007);
    chk(addressStrobeIn, 16'h0000);
    @(posedge ref_clk);
    hostAddr <= 4'hB;
    tick;
    chk(addressStrobeIn, 16'h0001);
  endtask

  // Host drive request must not reach the pins in port mode
  task automatic testGpio;
    @(posedge ref_clk);
    hostDrive <= 1'b1;
    gpioDir <= 16'h22F0;
    gpioOut <= 16'h23A5;
    hostData <= 8'h3C;
    hostAddr <= 4'b0101;
    setCtrl(16'h0000);
    tick;
    chk(dataPinOe, 16'h00F0);
    chk(dataPinOut & dataPinOe, 16'h00A0);
    chk({addrPinOe, addrPinOut & addrPinOe}, 16'h00AA);
    chk(gpioIn & 16'hDD0F, 16'h050C);
  endtask

  task automatic testStopWait;
    @(posedge ref_clk);
    stopMode <= 1'b1;
    ctrlWr <= 1'b1;
    ctrlIn <= 16'h0003;
    hostData <= 8'h00;
    tick;
    chk({dataPinOe, addrPinOe}, 16'h0000);
    @(posedge ref_clk);
    ctrlWr <= 1'b0;
    tick;
    chk(ctrlRd, 16'h0000);
    chk(gpioIn & 16'hDD0F, 16'h050C);
    @(posedge ref_clk);
    stopMode <= 1'b0;
    waitMode <= 1'b1;
    repeat (2) tick;
    chk({dataPinOe, 4'h0, addrPinOe}, 16'hF00A);
    chk(ctrlRd, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) tick;
    checkQuiet;
    @(posedge ref_clk);
    rst_b <= 1'b1;
    testNonMux;
    testMux;
    testGpio;
    testStopWait;
    @(posedge ref_clk);
    rst_b <= 1'b0;
    tick;
    checkQuiet;
    @(posedge ref_clk);
    rst_b <= 1'b1;
    waitMode <= 1'b0;
    tick;
    endOfTest;
  end

  // Guard against a hung run
  initial begin
    repeat (20000) @(posedge ref_clk);
    errTotal++;
    endOfTest;
  end
endmodule
